// file: dsfe_status_encoder.v
// serialises time, supply, diagnosis and sentence fields into a byte stream
//
// Behaviour
// (RULE1) multi-byte fields go most significant first
// (RULE2) millisecond: bits 9:8 then 7:0
// (RULE3) microsecond uses same ten-bit two-byte layout
// (RULE4) supply block: two currents, six voltages
// (RULE5) current: sign bit 23, magnitude 22:0
// (RULE6) voltage: top four bits zero, code low
// (RULE7) host scales voltage codes per rail
// (RULE8) compensation byte zero when working
// (RULE9) single and double bit error counters
// (RULE10) temps one-two bottom, three-four top
// (RULE11) temps 1-4: bits 15:3, 2:0 zero
// (RULE12) temp five: 12-bit value, top zero
// (RULE13) time status: pulse bit0, sentence bit1
// (RULE14) bit2 set only while timestamp synced
// (RULE15) motor speed high then low byte
// (RULE16) debug bytes free, host ignores them
// (RULE17) 86-byte stored positioning sentence in ascii
// (RULE18) reserved bits and bytes sent zero
`timescale 1ns/1ps
`include "dsfe_defs.vh"
module dsfe_status_encoder (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // frame control
  input  wire        start_i,              // pulse: begin encoding a field set
  input  wire        byte_ready_i,         // consumer takes byte when valid
  // time fields
  input  wire [9:0]  millisecond_field_i,
  input  wire [9:0]  microsecond_field_i,
  // supply fields
  input  wire        sensor_supply_negative_i,
  input  wire [22:0] sensor_supply_current_i,
  input  wire        top_supply_negative_i,
  input  wire [22:0] top_board_supply_current_i,
  input  wire [71:0] rail_voltage_codes_i, // six 12-bit codes, rail 0 in low bits
  // diagnosis fields
  input  wire [7:0]  temp_compensation_state_i,
  input  wire [15:0] single_bit_error_count_i,
  input  wire [15:0] double_bit_error_count_i,
  input  wire        pulse_valid_flag_i,
  input  wire        sentence_valid_flag_i,
  input  wire        timestamp_sync_flag_i,
  input  wire [51:0] board_temp_codes_i,   // four 13-bit codes, temperature one low
  input  wire [11:0] bottom_temp5_code_i,
  input  wire [15:0] motor_speed_i,        // high byte then low byte on the wire
  // sentence store write port
  input  wire        sentence_wr_i,
  input  wire [6:0]  sentence_addr_i,
  input  wire [7:0]  sentence_data_i,
  // byte stream out
  output reg  [7:0]  byte_data_o,
  output reg         byte_valid_o,
  output reg         frame_last_o,
  output reg         busy_o
);
  // state codes
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SEND = 2'b01;

  reg  [1:0]  state;                       // current state
  reg  [7:0]  idx;                         // stream byte index
  reg  [7:0]  sentence_mem [0:85];         // stored positioning sentence
  reg  [9:0]  ms_snap;                     // snapshots keep the time fields coherent for one frame
  reg  [9:0]  us_snap;
  reg  [7:0]  next_byte;                   // byte chosen for current index
  reg  [7:0]  rel;                         // index within the active block
  reg  [23:0] cur_word;                    // selected current field
  reg  [15:0] volt_word;                   // selected voltage field
  reg  [15:0] temp_word;                   // selected temperature field
  wire [7:0]  ms_byte;
  wire [7:0]  us_byte;
  wire [7:0]  volt_byte;
  wire [7:0]  temp_byte;
  wire [7:0]  t5_byte;
  wire [7:0]  tsrc_byte;
  reg  [7:0]  vi;                          // voltage field number
  reg  [7:0]  ti;                          // temperature field number

  // (RULE2) millisecond byte split
  dsfe_field_split #(.KEEP_MASK(16'h03ff)) u_ms (
    .value_i   ({6'h00, ms_snap}),
    .sel_low_i (idx[0]),
    .byte_o    (ms_byte)
  );
  // (RULE3) microsecond byte split
  dsfe_field_split #(.KEEP_MASK(16'h03ff)) u_us (
    .value_i   ({6'h00, us_snap}),
    .sel_low_i (idx[0]),
    .byte_o    (us_byte)
  );
  // (RULE6) voltage unused nibble zero
  dsfe_field_split #(.KEEP_MASK(16'h0fff)) u_volt (
    .value_i   (volt_word),
    .sel_low_i (rel[0]),
    .byte_o    (volt_byte)
  );
  // (RULE11) temp low bits zero
  dsfe_field_split #(.KEEP_MASK(16'hfff8)) u_temp (
    .value_i   (temp_word),
    .sel_low_i (rel[0]),
    .byte_o    (temp_byte)
  );
  // (RULE12) temp five top nibble zero
  dsfe_field_split #(.KEEP_MASK(16'h0fff)) u_t5 (
    .value_i   ({4'h0, bottom_temp5_code_i}),
    .sel_low_i (rel[0]),
    .byte_o    (t5_byte)
  );

  // (RULE13) time-source status byte, reserved bits zero
  // (RULE14) sync flag follows live lock
  assign tsrc_byte = {5'h00, timestamp_sync_flag_i, sentence_valid_flag_i, pulse_valid_flag_i};

  // sentence store, written when the receiver delivers a character at an address below 86
  always @(posedge clk_sys_i) begin
    // (RULE17) keep full sentence text
    if (sentence_wr_i && ({1'b0, sentence_addr_i} < `DSFE_SENTENCE_LEN)) begin
      sentence_mem[sentence_addr_i] <= sentence_data_i;
    end
  end

  // pick the byte for the current stream index
  always @* begin
    next_byte = 8'h00;
    rel       = 8'h00;
    cur_word  = 24'h000000;
    volt_word = 16'h0000;
    temp_word = 16'h0000;
    vi        = 8'h00;
    ti        = 8'h00;
    if (idx < `DSFE_OFF_US) begin
      next_byte = ms_byte;
    end else if (idx < `DSFE_OFF_STATUS) begin
      next_byte = us_byte;
    end else if (idx < `DSFE_OFF_DIAG) begin
      // (RULE4) currents then six voltages
      rel = idx - `DSFE_OFF_STATUS;
      if (rel < 8'h06) begin
        // (RULE5) sign over magnitude
        cur_word = (rel < 8'h03) ? {sensor_supply_negative_i, sensor_supply_current_i}
                                 : {top_supply_negative_i, top_board_supply_current_i};
        // (RULE1) most significant first
        case (rel)
          8'h00, 8'h03: next_byte = cur_word[23:16];
          8'h01, 8'h04: next_byte = cur_word[15:8];
          default:      next_byte = cur_word[7:0];
        endcase
      end else begin
        vi        = (rel - 8'h06) >> 1;
        volt_word = {4'h0, rail_voltage_codes_i[vi*12 +: 12]};
        next_byte = volt_byte;
      end
    end else if (idx < `DSFE_OFF_SENTENCE) begin
      rel = idx - `DSFE_OFF_DIAG;
      if (rel >= `DSFE_DG_TEMP1 && rel < `DSFE_DG_TEMP1 + 8'h08) begin
        // (RULE10) fields one-four in order
        ti        = (rel - `DSFE_DG_TEMP1) >> 1;
        temp_word = {board_temp_codes_i[ti*13 +: 13], 3'h0};
        next_byte = temp_byte;
      end else if (rel == `DSFE_DG_TEMP1 + 8'h08 || rel == `DSFE_DG_TEMP1 + 8'h09) begin
        next_byte = t5_byte;
      end else begin
        case (rel)
          // (RULE8) compensation state passed through
          `DSFE_DG_COMP:    next_byte = temp_compensation_state_i;
          // (RULE9) error counters, high first
          `DSFE_DG_ERR1_H:  next_byte = single_bit_error_count_i[15:8];
          `DSFE_DG_ERR1_L:  next_byte = single_bit_error_count_i[7:0];
          `DSFE_DG_ERR2_H:  next_byte = double_bit_error_count_i[15:8];
          `DSFE_DG_ERR2_L:  next_byte = double_bit_error_count_i[7:0];
          `DSFE_DG_TSRC:    next_byte = tsrc_byte;
          // (RULE15) speed high then low
          `DSFE_DG_SPEED_H: next_byte = motor_speed_i[15:8];
          `DSFE_DG_SPEED_L: next_byte = motor_speed_i[7:0];
          // (RULE16) debug bytes sent zero
          // (RULE18) reserved bytes zero
          default:          next_byte = 8'h00;
        endcase
      end
    end else begin
      rel       = idx - `DSFE_OFF_SENTENCE;
      next_byte = sentence_mem[rel[6:0]];
    end
  end

  // stream sequencer; a byte holds until the consumer takes it
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      idx          <= 8'h00;
      ms_snap      <= 10'h000;
      us_snap      <= 10'h000;
      byte_data_o  <= 8'h00;
      byte_valid_o <= 1'b0;
      frame_last_o <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          byte_valid_o <= 1'b0;
          frame_last_o <= 1'b0;
          if (start_i) begin
            // out-of-range time clamps to the top legal value
            ms_snap <= (millisecond_field_i > `DSFE_TIME_MAX) ? `DSFE_TIME_MAX : millisecond_field_i;
            us_snap <= (microsecond_field_i > `DSFE_TIME_MAX) ? `DSFE_TIME_MAX : microsecond_field_i;
            idx     <= 8'h00;
            busy_o  <= 1'b1;
            state   <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (!byte_valid_o || byte_ready_i) begin
            if (byte_valid_o && frame_last_o) begin
              byte_valid_o <= 1'b0;
              frame_last_o <= 1'b0;
              busy_o       <= 1'b0;
              state        <= ST_IDLE;
            end else begin
              byte_data_o  <= next_byte;
              byte_valid_o <= 1'b1;
              frame_last_o <= (idx == `DSFE_TOTAL_BYTES - 8'h01);
              idx          <= idx + 8'h01;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // dsfe_status_encoder

// file: dsfe_defs.vh
// constants for the device status field encoder
`ifndef DSFE_DEFS_VH
`define DSFE_DEFS_VH
// stream byte offsets (0-based) inside the encoded field area
`define DSFE_OFF_MS        8'h00
`define DSFE_OFF_US        8'h02
`define DSFE_OFF_STATUS    8'h04
`define DSFE_OFF_DIAG      8'h16
`define DSFE_OFF_SENTENCE  8'h3e
`define DSFE_TOTAL_BYTES   8'h94
// block lengths
`define DSFE_STATUS_LEN    8'h12
`define DSFE_DIAG_LEN      8'h28
`define DSFE_SENTENCE_LEN  8'h56
// diagnosis byte indices (0-based within the diagnosis block)
`define DSFE_DG_COMP       8'h0a
`define DSFE_DG_ERR1_H     8'h0b
`define DSFE_DG_ERR1_L     8'h0c
`define DSFE_DG_ERR2_H     8'h0d
`define DSFE_DG_ERR2_L     8'h0e
`define DSFE_DG_TSRC       8'h0f
`define DSFE_DG_TEMP1      8'h10
`define DSFE_DG_DEBUG      8'h1a
`define DSFE_DG_SPEED_H    8'h1f
`define DSFE_DG_SPEED_L    8'h20
// time-source status bit positions
`define DSFE_TS_PULSE      0
`define DSFE_TS_SENT       1
`define DSFE_TS_SYNC       2
// value limits
`define DSFE_TIME_MAX      10'h3e7
`endif

// file: dsfe_field_split.v
// splits a 16-bit field into big-endian bytes with a kept-bit mask
`timescale 1ns/1ps
module dsfe_field_split #(
  parameter [15:0] KEEP_MASK = 16'hffff    // bits passed through, others zero
) (
  // field input
  input  wire [15:0] value_i,
  input  wire        sel_low_i,            // 1 selects the second (low) byte
  // byte output
  output wire [7:0]  byte_o
);
  wire [15:0] masked;                      // reserved bits forced to zero
  assign masked = value_i & KEEP_MASK;
  // high byte first on the wire
  assign byte_o = sel_low_i ? masked[7:0] : masked[15:8];
endmodule // dsfe_field_split

// file: dsfe_status_encoder_sva.sv
// checker for the status encoder byte stream
`timescale 1ns/1ps
module dsfe_status_encoder_sva (
  // clock and control
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       start_i,
  input wire       byte_ready_i,
  // time source flags
  input wire       pulse_valid_flag_i,
  input wire       sentence_valid_flag_i,
  input wire       timestamp_sync_flag_i,
  // byte stream
  input wire [7:0] byte_data_o,
  input wire       byte_valid_o,
  input wire       frame_last_o,
  input wire       busy_o
);
  reg  [7:0] pos;                                 // index of byte on offer
  wire       take = byte_valid_o && byte_ready_i; // byte accepted at this edge
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // byte index, cleared while idle so each frame restarts at zero
  always @(posedge clk_sys_i) begin
    if (rst_i || !busy_o) pos <= 8'h00;
    else if (take) pos <= pos + 8'h01;
  end
  AST_HOLD: assert property (byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o))
    else $error("byte changed before it was taken");
  AST_START: assert property (start_i && !busy_o |=> busy_o ##1 (byte_valid_o && byte_data_o[7:2] == 6'h00))
    else $error("first byte late or top bits set");
  AST_US_HI: assert property (byte_valid_o && pos == 8'h02 |-> byte_data_o[7:2] == 6'h00)
    else $error("microsecond top bits set");
  AST_LEN: assert property (byte_valid_o |-> frame_last_o == (pos == 8'h93))
    else $error("last flag on wrong byte");
  AST_VOLT: assert property (byte_valid_o && pos >= 8'h0a && pos <= 8'h14 && !pos[0] |-> byte_data_o[7:4] == 4'h0)
    else $error("voltage top bits set");
  // flags are judged as they stood at the edge that loaded the byte, so a stall cannot blur them
  AST_TSRC: assert property (byte_valid_o && pos == 8'h25 && $changed(pos) |->
    byte_data_o == {5'h00, $past(timestamp_sync_flag_i), $past(sentence_valid_flag_i), $past(pulse_valid_flag_i)})
    else $error("time source byte wrong");
  AST_TEMP: assert property (byte_valid_o && pos inside {8'h27, 8'h29, 8'h2b, 8'h2d} |-> byte_data_o[2:0] == 3'h0)
    else $error("temperature low bits set");
  AST_T5: assert property (byte_valid_o && pos == 8'h2e |-> byte_data_o[7:4] == 4'h0)
    else $error("temperature five top bits set");
  AST_END: assert property (take && frame_last_o |=> !byte_valid_o ##[0:1] !busy_o)
    else $error("stream did not stop after last byte");
  cover property (start_i && !busy_o);
  cover property (byte_valid_o && !byte_ready_i);
  cover property (take && frame_last_o);
endmodule // dsfe_status_encoder_sva

bind dsfe_status_encoder dsfe_status_encoder_sva i_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
  .byte_ready_i(byte_ready_i), .pulse_valid_flag_i(pulse_valid_flag_i), .sentence_valid_flag_i(sentence_valid_flag_i),
  .timestamp_sync_flag_i(timestamp_sync_flag_i), .byte_data_o(byte_data_o), .byte_valid_o(byte_valid_o),
  .frame_last_o(frame_last_o), .busy_o(busy_o));

// file: dsfe_host_model.sv
// host side model that takes the encoded byte stream
`timescale 1ns/1ps
module dsfe_host_model (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_i,
  // stream from the device
  input  wire [7:0] byte_data_i,
  input  wire       byte_valid_i,
  input  wire       frame_last_i,
  input  wire       stall_i,      // 1 drops ready every other cycle
  output reg        byte_ready_o,
  output reg  [7:0] got_count_o   // length of the last finished frame
);
  reg [7:0] rx [0:147];           // frame kept in wire order
  reg [7:0] idx;                  // next free slot
  // take bytes; ready moves just after the edge, never at it
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      idx          <= 8'h00;
      got_count_o  <= 8'h00;
      byte_ready_o <= #2 1'b0;
    end else begin
      if (byte_valid_i && byte_ready_o) begin
        rx[idx] <= byte_data_i;
        idx     <= frame_last_i ? 8'h00 : idx + 8'h01;
        if (frame_last_i) got_count_o <= idx + 8'h01;
      end
      byte_ready_o <= #2 (stall_i ? ~byte_ready_o : 1'b1);
    end
  end
endmodule // dsfe_host_model

// file: tb_device_status_field_encoder.sv
// self-checking bench for the status field encoder
`timescale 1ns/1ps
module tb_device_status_field_encoder;
  reg         clk_sys_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         start_i = 1'b0;
  reg         stall = 1'b0;
  reg  [9:0]  ms = 10'h000, us = 10'h000;
  reg         neg1 = 1'b0, neg2 = 1'b0;
  reg  [22:0] cur1 = 23'h0, cur2 = 23'h0;
  reg  [71:0] volt = 72'h0;
  reg  [7:0]  comp = 8'h00;
  reg  [15:0] err1 = 16'h0, err2 = 16'h0, speed = 16'h0;
  reg  [2:0]  flags = 3'h0;       // sync, sentence, pulse
  reg  [51:0] temps = 52'h0;
  reg  [11:0] t5 = 12'h000;
  reg         wr = 1'b0;
  reg  [6:0]  addr = 7'h00;
  reg  [7:0]  wdat = 8'h00;
  wire [7:0]  bdat, got;
  wire        bval, last, busy, ready;
  reg  [7:0]  e [0:147];          // expected frame
  integer     err_count = 0;
  integer     samples_checked = 0;
  integer     k;
  always #25 clk_sys_i = ~clk_sys_i;
  dsfe_status_encoder i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .byte_ready_i(ready),
    .millisecond_field_i(ms), .microsecond_field_i(us), .sensor_supply_negative_i(neg1),
    .sensor_supply_current_i(cur1), .top_supply_negative_i(neg2), .top_board_supply_current_i(cur2),
    .rail_voltage_codes_i(volt), .temp_compensation_state_i(comp), .single_bit_error_count_i(err1),
    .double_bit_error_count_i(err2), .pulse_valid_flag_i(flags[0]), .sentence_valid_flag_i(flags[1]),
    .timestamp_sync_flag_i(flags[2]), .board_temp_codes_i(temps), .bottom_temp5_code_i(t5),
    .motor_speed_i(speed), .sentence_wr_i(wr), .sentence_addr_i(addr), .sentence_data_i(wdat),
    .byte_data_o(bdat), .byte_valid_o(bval), .frame_last_o(last), .busy_o(busy));
  dsfe_host_model i_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .byte_data_i(bdat), .byte_valid_i(bval),
    .frame_last_i(last), .stall_i(stall), .byte_ready_o(ready), .got_count_o(got));
  task chk(input [7:0] g, input [7:0] x);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task close_out;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // expected bytes from the inputs; over-range time clamps to 999
  task fill_exp;
    reg [9:0] mc;
    reg [9:0] uc;
    begin
      mc = (ms > 10'h3e7) ? 10'h3e7 : ms;
      uc = (us > 10'h3e7) ? 10'h3e7 : us;
      for (k = 0; k < 148; k = k + 1) e[k] = (k >= 62) ? 8'h41 + k[7:0] - 8'h3e : 8'h00;
      {e[0], e[1], e[2], e[3]} = {6'h00, mc, 6'h00, uc};
      {e[4], e[5], e[6], e[7], e[8], e[9]} = {neg1, cur1, neg2, cur2};
      for (k = 0; k < 6; k = k + 1) {e[10+2*k], e[11+2*k]} = {4'h0, volt[12*k +: 12]};
      {e[32], e[33], e[34], e[35], e[36], e[37]} = {comp, err1, err2, 5'h00, flags};
      for (k = 0; k < 4; k = k + 1) {e[38+2*k], e[39+2*k]} = {temps[13*k +: 13], 3'h0};
      {e[46], e[47], e[53], e[54]} = {4'h0, t5, speed};
    end
  endtask
  // one frame; poke pulses start again mid-frame, which must be ignored
  task run_frame(input poke);
    integer i;
    reg     done;
    begin
      fill_exp;
      @(posedge clk_sys_i) #2 start_i = 1'b1;
      @(posedge clk_sys_i) #2 start_i = 1'b0;
      done = 1'b0;
      for (i = 0; i < 600 && !done; i = i + 1) begin
        // handshake looked at mid-cycle, where it is settled
        @(negedge clk_sys_i);
        done = bval && ready && last;
        @(posedge clk_sys_i);
        #2 start_i = poke && (i == 20);
      end
      if (!done) begin
        err_count = err_count + 1;
        close_out;
      end else begin
        repeat (2) @(posedge clk_sys_i);
        #2 chk({6'h00, busy, bval}, 8'h00);
        chk(got, 8'h94);
        for (k = 0; k < 148; k = k + 1) if (k < 48 || k > 52) chk(i_host.rx[k], e[k]);
      end
    end
  endtask
  task t_edge_values;
    reg [15:0] v;
    begin
      @(posedge clk_sys_i) #2 {ms, us, neg1, cur1, neg2, cur2, comp, err1, err2, flags, t5, speed} =
        {10'h3ff, 10'h3e7, 1'b1, 23'h0cd500, 1'b1, 23'h7fffff, 8'h00, 16'hffff, 16'h0001, 3'h3, 12'h800, 16'h1770};
      {volt, temps} = {72'hfff_abc_123_800_001_fff, 13'h1fff, 13'h1000, 13'h0fff, 13'h0001};
      run_frame(1'b0);
      // host scales the 12 V rail code by 12 and the 5 V rail code by 4
      v = {4'h0, i_host.rx[10][3:0], i_host.rx[11]} * 16'h000c;
      chk(v[15:8], 8'hbf);
      v = {4'h0, i_host.rx[14][3:0], i_host.rx[15]} * 16'h0004;
      chk(v[15:8], 8'h20);
    end
  endtask
  task t_stall_restart;
    begin
      @(posedge clk_sys_i) #2 {ms, us, neg1, cur1, neg2, comp, err1, t5, speed, stall} =
        {10'h000, 10'h3ff, 1'b0, 23'h000001, 1'b0, 8'h5a, 16'h0000, 12'h7ff, 16'hff00, 1'b1};
      run_frame(1'b1);
      @(posedge clk_sys_i) #2 stall = 1'b0;
    end
  endtask
  task t_flag_codes;
    integer f;
    begin
      for (f = 0; f < 8; f = f + 1) begin
        @(posedge clk_sys_i) #2 {flags, comp} = {f[2:0], 8'h00};
        run_frame(1'b0);
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #2 rst_i = 1'b0;
    chk({6'h00, busy, bval}, 8'h00);
    // address 86 lies past the store and is dropped
    for (k = 0; k < 87; k = k + 1) @(posedge clk_sys_i) #2 {wr, addr, wdat} = {1'b1, k[6:0], 8'h41 + k[7:0]};
    @(posedge clk_sys_i) #2 wr = 1'b0;
    t_edge_values;
    t_stall_restart;
    t_flag_codes;
    close_out;
  end
endmodule // tb_device_status_field_encoder
